// ===== dv/tb_bitmap_video_memory_ctrl.sv
// Bench for the host end and the video memory end joined by their bus.
`timescale 1ns/1ps
`default_nettype none

module tb_bitmap_video_memory_ctrl;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    logic [21:0] cmd_addr = 22'h0;
    logic [31:0] cmd_wdata = 32'h0;
    logic [3:0]  cmd_be = 4'h0;
    logic [3:0]  base = 4'ha;
    logic        de = 1'b1;
    logic [3:0]  raster = 4'h0;
    logic [5:0]  charh = 6'h0;
    logic [4:0]  word = 5'h0;
    logic        cursor_window_win = 1'b0;
    logic        hsync = 1'b0;
    logic [9:0]  cursor_window_x = 10'h0;
    logic        or_mode = 1'b0;
    logic        half = 1'b0;
    logic        cmd_ready, resp_valid, upd, coln, rs, cs, pix_v;
    logic [31:0] resp_rdata, pix, rd, w1, w2;
    logic [7:0]  mux, rcnt, c0;
    logic [3:0]  bws, b;
    logic [1:0]  mws, cws;
    logic [21:0] a;
    logic [10:0] line;
    logic [9:0]  idx;
    logic [4:0]  wi;
    logic [4:0]  wtab [4] = '{5'h02, 5'h18, 5'h19, 5'h1f};
    int          n_fail = 0;
    int          n_tests = 0;
    int          seed = 32'h5a13c1c9;

    video_bus_if u_video_bus_if ();

    video_mem_host u_video_mem_host
    (
        .clock_i(clock_i), .rst_i(rst_i), .bus(u_video_bus_if),
        .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_be_i(cmd_be),
        .cmd_ready_o(cmd_ready), .resp_valid_o(resp_valid),
        .resp_rdata_o(resp_rdata)
    );

    video_mem_device u_video_mem_device
    (
        .clock_i(clock_i), .rst_i(rst_i), .bus(u_video_bus_if),
        .window_base_address_i(base), .display_window_active_i(de),
        .ctrl_raster_row_i(raster), .ctrl_char_addr_high_i(charh),
        .ctrl_word_index_i(word), .cursor_window_i(cursor_window_win),
        .hsync_i(hsync), .cursor_x_i(cursor_window_x), .cursor_or_mode_i(or_mode),
        .half_page_i(half), .update_phase_select_o(upd),
        .column_phase_n_o(coln), .dram_mux_address_o(mux),
        .row_strobe_timing_o(rs), .col_strobe_timing_o(cs),
        .byte_write_strobes_o(bws), .map_write_strobes_o(mws),
        .cursor_write_strobes_o(cws), .refresh_row_count_o(rcnt),
        .pixel_word_o(pix), .pixel_valid_o(pix_v)
    );

    video_mem_properties u_video_mem_properties
    (
        .clock_i(clock_i), .rst_i(rst_i), .req(u_video_bus_if.req),
        .write(u_video_bus_if.write), .addr(u_video_bus_if.addr),
        .be(u_video_bus_if.be), .ack(u_video_bus_if.ack),
        .window_base_address_i(base), .update_phase_select_o(upd),
        .column_phase_n_o(coln), .row_strobe_timing_o(rs),
        .col_strobe_timing_o(cs), .dram_mux_address_o(mux),
        .byte_write_strobes_o(bws), .map_write_strobes_o(mws),
        .cursor_write_strobes_o(cws), .refresh_row_count_o(rcnt)
    );

    initial
    begin
        forever #4 clock_i = ~clock_i;
    end

    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] n, input logic [3:0] m);
        for (int i = 0; i < 4; i++)
            if (m[i])
                o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction

    task automatic report_and_stop();
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded so that a lost answer ends the run instead of hanging it.
    task automatic wait_for(ref logic s);
        int k;
        k = 0;
        do
        begin
            @(negedge clock_i);
            k++;
        end
        while (s !== 1'b1 && k < 400);
        if (s !== 1'b1)
        begin
            n_fail++;
            $display("Error at %0t: handshake timed out", $time);
            report_and_stop();
        end
    endtask

    task automatic xfer(input logic wr, input logic [21:0] ad,
        input logic [31:0] d, input logic [3:0] m);
        @(posedge clock_i);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= ad;
        cmd_wdata <= d;
        cmd_be <= m;
        @(posedge clock_i);
        cmd_valid <= 1'b0;
        wait_for(resp_valid);
        rd = resp_rdata;
        check({31'h0, cmd_ready}, 32'h1);
    endtask

    // The first fetch may use inputs sampled before the change, so the
    // second one is the one compared.
    task automatic fetch(input logic [4:0] w, input logic [31:0] exp);
        @(posedge clock_i);
        raster <= idx[9:6];
        charh <= idx[5:0];
        word <= w;
        wait_for(pix_v);
        wait_for(pix_v);
        check(pix, exp);
    endtask

    initial
    begin
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            line = 11'($random(seed)) % 11'h7f0;
            a = {base, line, 5'($random(seed)), 2'b00};
            w1 = $random(seed);
            w2 = $random(seed);
            b = (i == 0) ? 4'h0 : 4'($random(seed));
            xfer(1'b1, a, w1, 4'hf);
            xfer(1'b1, a, w2, b);
            xfer(1'b0, a, 32'h0, 4'hf);
            check(rd, merge(w1, w2, b));
            xfer(1'b1, {~base, a[17:0]}, ~w1, 4'hf);
            xfer(1'b0, {~base, a[17:0]}, 32'h0, 4'hf);
            check(rd, 32'h0);
            xfer(1'b0, a, 32'h0, 4'hf);
            check(rd, merge(w1, w2, b));
        end
        for (int i = 0; i < 4; i++)
        begin
            line = 11'($random(seed)) % 11'h7f0;
            idx = 10'($random(seed)) % 10'h3f0;
            wi = wtab[i];
            w1 = $random(seed);
            w2 = idx[0] ? {5'h0, line, 16'h0} : {16'h0, 5'h0, line};
            xfer(1'b1, {base, 7'h7f, idx[9:1], 2'b00}, w2,
                 idx[0] ? 4'hc : 4'h3);
            xfer(1'b1, {base, line, wi, 2'b00}, w1, 4'hf);
            @(posedge clock_i);
            half <= (i == 1 || i == 2);
            rd = (i == 2) ? 32'h0 : w1;
            fetch(wi, rd);
        end
        w1 = $random(seed);
        w2 = $random(seed);
        xfer(1'b1, {base, 13'h1fff, 5'h00}, w1, 4'hf);
        xfer(1'b1, {base, line, 5'h04, 2'b00}, w2, 4'hf);
        @(posedge clock_i);
        half <= 1'b0;
        cursor_window_x <= 10'h080;
        cursor_window_win <= 1'b1;
        or_mode <= 1'b1;
        fetch(5'h04, w2 | {16'h0, w1[15:0]});
        @(posedge clock_i);
        hsync <= 1'b1;
        or_mode <= 1'b0;
        @(posedge clock_i);
        hsync <= 1'b0;
        fetch(5'h04, {w2[31:16], w2[15:0] & w1[31:16]});
        // An origin past the last legal column must land on column 1007.
        xfer(1'b1, {base, line, 5'h1f, 2'b00}, w2, 4'hf);
        @(posedge clock_i);
        cursor_window_x <= 10'h3ff;
        fetch(5'h1f, w2 & {1'b1, w1[31:16], 15'h7fff});
        @(posedge clock_i);
        de <= 1'b0;
        repeat (116) @(posedge clock_i);
        @(negedge clock_i);
        c0 = rcnt;
        repeat (1160) @(negedge clock_i);
        check({24'h0, rcnt}, {24'h0, c0 + 8'h0a});
        @(posedge clock_i);
        de <= 1'b1;
        repeat (116) @(posedge clock_i);
        @(negedge clock_i);
        c0 = rcnt;
        repeat (1160) @(negedge clock_i);
        check({24'h0, rcnt}, {24'h0, c0});
        report_and_stop();
    end
endmodule

`default_nettype wire

// ===== dv/video_mem_properties.sv
// Concurrent checks on the link between the host end and memory end, and on the memory end's sequencer, strobes and refresh count.
`timescale 1ns/1ps
`default_nettype none

module video_mem_properties
(
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        req,
    input wire logic        write,
    input wire logic [21:0] addr,
    input wire logic [3:0]  be,
    input wire logic        ack,
    input wire logic [3:0]  window_base_address_i,
    input wire logic        update_phase_select_o,
    input wire logic        column_phase_n_o,
    input wire logic        row_strobe_timing_o,
    input wire logic        col_strobe_timing_o,
    input wire logic [7:0]  dram_mux_address_o,
    input wire logic [3:0]  byte_write_strobes_o,
    input wire logic [1:0]  map_write_strobes_o,
    input wire logic [1:0]  cursor_write_strobes_o,
    input wire logic [7:0]  refresh_row_count_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    property p_req_served;
        $rose(req) |-> ##[1:120] ack;
    endproperty
    a_req_served: assert property (p_req_served)
        else $error("bus request not answered within one access cycle");
    property p_ack_spacing;
        ack |=> !ack [*8];
    endproperty
    a_ack_spacing: assert property (p_ack_spacing)
        else $error("two answers too close together");
    // The refresh half is 58 clocks, so update must return 58 clocks later.
    property p_half_split;
        $fell(update_phase_select_o) |->
            column_phase_n_o ##1 row_strobe_timing_o ##57 update_phase_select_o;
    endproperty
    a_half_split: assert property (p_half_split)
        else $error("access cycle halves out of step");
    property p_mux_phase;
        row_strobe_timing_o |->
            column_phase_n_o ##1 (col_strobe_timing_o && !column_phase_n_o);
    endproperty
    a_mux_phase: assert property (p_mux_phase)
        else $error("row or column select out of order");
    property p_update_addr;
        ack && addr[21:18] == window_base_address_i |->
            $past(dram_mux_address_o, 3) == addr[14:7] &&
            $past(dram_mux_address_o, 2) == {addr[17:15], addr[6:2]};
    endproperty
    a_update_addr: assert property (p_update_addr)
        else $error("update row or column address wrong");
    property p_byte_strobes;
        |byte_write_strobes_o |-> write && byte_write_strobes_o == be &&
            addr[21:18] == window_base_address_i ##1 ack;
    endproperty
    a_byte_strobes: assert property (p_byte_strobes)
        else $error("byte strobes do not match the write");
    property p_map_strobes;
        |map_write_strobes_o |->
            write && addr[17:11] == 7'h7f && update_phase_select_o;
    endproperty
    a_map_strobes: assert property (p_map_strobes)
        else $error("map written outside its region or slot");
    property p_cursor_strobes;
        |cursor_write_strobes_o |->
            write && &addr[17:5] && update_phase_select_o &&
            addr[21:18] == window_base_address_i;
    endproperty
    a_cursor_strobes: assert property (p_cursor_strobes)
        else $error("cursor written outside its region or slot");
    property p_refresh_step;
        $changed(refresh_row_count_o) |-> !$past(update_phase_select_o) &&
            refresh_row_count_o == $past(refresh_row_count_o) + 8'h01;
    endproperty
    a_refresh_step: assert property (p_refresh_step)
        else $error("refresh count stepped wrongly");
endmodule

`default_nettype wire

// ===== shared/video_bus_if.sv
// Parallel bus between the host end and the video memory end.
`timescale 1ns/1ps
`default_nettype none

interface video_bus_if;
    logic        req;
    logic        write;
    logic [21:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        ack;
    logic [31:0] rdata;

    modport device
    (
        input  req, write, addr, wdata, be,
        output ack, rdata
    );

    modport host
    (
        output req, write, addr, wdata, be,
        input  ack, rdata
    );
endinterface

`default_nettype wire

// ===== shared/video_mem_pkg.sv
// Shared constants for the bitmap video memory and its bus.
package video_mem_pkg;

    // ------------------------------------------------------------
    // Access cycle timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 8;
    localparam int ACCESS_CYCLE_NS = 925;
    localparam logic [6:0] CYCLE_CLKS =
        7'((ACCESS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] HALF_CLKS  = 7'(CYCLE_CLKS >> 1);
    localparam logic [6:0] ROW_STEP   = 7'h01;
    localparam logic [6:0] COL_STEP   = 7'h02;
    localparam logic [6:0] ACC_STEP   = 7'h03;

    // ------------------------------------------------------------
    // Memory address multiplexer selects
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_REFRESH_COL = 2'h0;
    localparam logic [1:0] SEL_REFRESH_ROW = 2'h1;
    localparam logic [1:0] SEL_UPDATE_COL  = 2'h2;
    localparam logic [1:0] SEL_UPDATE_ROW  = 2'h3;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int LINE_PIXELS    = 1024;
    localparam int FB_LINES       = 2048;
    localparam int WORDS_PER_LINE = 32;
    localparam int FB_WORDS       = LINE_PIXELS / 32 * FB_LINES;
    localparam int DISPLAY_LINES  = 864;
    localparam int RETRACE_LINES  = 37;
    localparam int SCREEN_MAX_X   = 1023;
    localparam int SCREEN_MAX_Y   = 863;
    localparam int MAP_ENTRIES    = 1024;
    localparam int MAP_WIDTH      = 11;
    localparam int CURSOR_SIZE    = 16;
    localparam logic [9:0] CURSOR_MAX_X = 10'h3ef;
    localparam int CURSOR_MAX_Y   = 847;
    localparam logic [4:0] HALF_PAGE_WORDS = 5'h19;

    // ------------------------------------------------------------
    // Bus address fields
    // ------------------------------------------------------------
    localparam int BUS_ADDR_W   = 22;
    localparam int WINDOW_LSB   = 18;
    localparam int MAP_SEL_LSB  = 11;
    localparam int CURSOR_WINDOW_SEL_LSB = 5;

endpackage

// ===== src/video_mem_device.sv
// Frame buffer, scan line map, cursor RAM and their access sequencer.
`timescale 1ns/1ps
`default_nettype none

module video_mem_device
    import video_mem_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    video_bus_if.device      bus,
    input  wire logic [3:0]  window_base_address_i,
    input  wire logic        display_window_active_i,
    input  wire logic [3:0]  ctrl_raster_row_i,
    input  wire logic [5:0]  ctrl_char_addr_high_i,
    input  wire logic [4:0]  ctrl_word_index_i,
    input  wire logic        cursor_window_i,
    input  wire logic        hsync_i,
    input  wire logic [9:0]  cursor_x_i,
    input  wire logic        cursor_or_mode_i,
    input  wire logic        half_page_i,
    output logic             update_phase_select_o,
    output logic             column_phase_n_o,
    output logic [7:0]       dram_mux_address_o,
    output logic             row_strobe_timing_o,
    output logic             col_strobe_timing_o,
    output logic [3:0]       byte_write_strobes_o,
    output logic [1:0]       map_write_strobes_o,
    output logic [1:0]       cursor_write_strobes_o,
    output logic [7:0]       refresh_row_count_o,
    output logic [31:0]      pixel_word_o,
    output logic             pixel_valid_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0]          fb_mem     [FB_WORDS];
    logic [MAP_WIDTH-1:0] map_mem    [MAP_ENTRIES];
    logic [15:0]          cursor_mem [CURSOR_SIZE];

    logic [6:0]           phase;
    logic [6:0]           rel;
    logic                 at_acc;
    logic                 active;
    logic                 cur_we;
    logic [21:0]          cur_addr;
    logic [31:0]          cur_wdata;
    logic [3:0]           cur_be;
    logic                 ack;
    logic [31:0]          rdata;
    logic [7:0]           row_latch;
    logic [7:0]           col_latch;
    logic [MAP_WIDTH-1:0] map_q;
    logic                 de_q;
    logic [4:0]           word_q;
    logic [7:0]           refresh_row_count;
    logic [7:0]           refresh_row_select;
    logic [3:0]           cursor_row_cnt;
    logic                 hsync_q;
    logic                 bitmap_select;
    logic                 map_hit;
    logic                 cursor_hit;
    logic                 host_acc;
    logic                 wr_go;
    logic                 disp_acc;
    logic [9:0]           cx;
    logic [47:0]          cdat48;
    logic [47:0]          carea48;
    logic [5:0]           cursor_word_next;
    logic [31:0]          cdat;
    logic [31:0]          carea;
    logic [31:0]          fb_word;
    logic [31:0]          next_pixel;

    // ------------------------------------------------------------
    // Access cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i || phase == CYCLE_CLKS - 7'h01)
            phase <= 7'h00;
        else
            phase <= phase + 7'h01;
    end

    // The first half serves the host, the second half the display.
    assign update_phase_select_o = phase < HALF_CLKS;
    assign rel = update_phase_select_o ? phase : phase - HALF_CLKS;
    assign column_phase_n_o = rel < COL_STEP;
    assign row_strobe_timing_o = rel == ROW_STEP;
    assign col_strobe_timing_o = rel == COL_STEP;
    assign at_acc = rel == ACC_STEP;
    assign host_acc = update_phase_select_o && at_acc && active;
    assign disp_acc = !update_phase_select_o && at_acc;

    // ------------------------------------------------------------
    // Host request capture
    // ------------------------------------------------------------
    // Requests are only taken at the very start of an update half, so a
    // late request never squeezes into a half that has already begun.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            active <= 1'b0;
        else if (phase == 7'h00 && bus.req && !active)
            active <= 1'b1;
        else if (host_acc)
            active <= 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cur_we    <= 1'b0;
            cur_addr  <= 22'h000000;
            cur_wdata <= 32'h00000000;
            cur_be    <= 4'h0;
        end
        else if (phase == 7'h00 && bus.req && !active)
        begin
            cur_we    <= bus.write;
            cur_addr  <= bus.addr;
            cur_wdata <= bus.wdata;
            cur_be    <= bus.be;
        end
    end

    assign bitmap_select = cur_addr[BUS_ADDR_W-1:WINDOW_LSB]
                           == window_base_address_i;
    assign map_hit    = bitmap_select && &cur_addr[17:MAP_SEL_LSB];
    assign cursor_hit = bitmap_select && &cur_addr[17:CURSOR_WINDOW_SEL_LSB];
    assign wr_go      = host_acc && cur_we && bitmap_select;

    assign byte_write_strobes_o = wr_go ? cur_be : 4'h0;
    assign map_write_strobes_o  = (wr_go && map_hit) ?
        {cur_be[3] | cur_be[1], cur_be[2] | cur_be[0]} : 2'h0;
    assign cursor_write_strobes_o = (wr_go && cursor_hit) ?
        {cur_be[3] | cur_be[1], cur_be[2] | cur_be[0]} : 2'h0;

    // ------------------------------------------------------------
    // DRAM address multiplexer
    // ------------------------------------------------------------
    assign refresh_row_select = de_q ? map_q[7:0] : refresh_row_count;

    always_comb
    begin
        case ({update_phase_select_o, column_phase_n_o})
            SEL_UPDATE_ROW:  dram_mux_address_o = cur_addr[14:7];
            SEL_UPDATE_COL:  dram_mux_address_o =
                                 {cur_addr[17:15], cur_addr[6:2]};
            SEL_REFRESH_ROW: dram_mux_address_o = refresh_row_select;
            default:         dram_mux_address_o =
                                 {map_q[10:8], word_q};
        endcase
    end

    // Row and column are latched from the mux just as the strobes would.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            row_latch <= 8'h00;
        else if (row_strobe_timing_o)
            row_latch <= dram_mux_address_o;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            col_latch <= 8'h00;
        else if (col_strobe_timing_o)
            col_latch <= dram_mux_address_o;
    end

    assign fb_word = fb_mem[{row_latch, col_latch}];

    // ------------------------------------------------------------
    // Frame buffer, map and cursor writes
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (wr_go)
            for (int b = 0; b < 4; b++)
                if (cur_be[b])
                    fb_mem[{row_latch, col_latch}][8*b +: 8] <=
                        cur_wdata[8*b +: 8];
    end

    // Each 16-bit half of the longword is its own map or cursor entry.
    always_ff @(posedge clock_i)
    begin
        if (wr_go && map_hit)
            for (int h = 0; h < 2; h++)
            begin
                if (cur_be[2*h])
                    map_mem[{cur_addr[10:2], h[0]}][7:0] <=
                        cur_wdata[16*h +: 8];
                if (cur_be[2*h+1])
                    map_mem[{cur_addr[10:2], h[0]}][10:8] <=
                        cur_wdata[16*h+8 +: 3];
            end
    end

    always_ff @(posedge clock_i)
    begin
        if (wr_go && cursor_hit)
            for (int h = 0; h < 2; h++)
            begin
                if (cur_be[2*h])
                    cursor_mem[{cur_addr[4:2], h[0]}][7:0] <=
                        cur_wdata[16*h +: 8];
                if (cur_be[2*h+1])
                    cursor_mem[{cur_addr[4:2], h[0]}][15:8] <=
                        cur_wdata[16*h+8 +: 8];
            end
    end

    // ------------------------------------------------------------
    // Host answer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            ack <= 1'b0;
        else
            ack <= host_acc;
    end

    // Map and cursor reads return frame buffer contents behind them.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            rdata <= 32'h00000000;
        else if (host_acc)
            rdata <= bitmap_select ? fb_word : 32'h00000000;
    end

    assign bus.ack   = ack;
    assign bus.rdata = rdata;

    // ------------------------------------------------------------
    // Display fetch and RAM refresh
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            map_q  <= '0;
            de_q   <= 1'b0;
            word_q <= 5'h00;
        end
        else if (phase == HALF_CLKS)
        begin
            // The controller walks the map through each frame.
            map_q  <= map_mem[{ctrl_raster_row_i,
                               ctrl_char_addr_high_i}];
            de_q   <= display_window_active_i;
            word_q <= ctrl_word_index_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            refresh_row_count <= 8'h00;
        else if (disp_acc && !de_q)
            refresh_row_count <= refresh_row_count + 8'h01;
    end

    assign refresh_row_count_o = refresh_row_count;

    // ------------------------------------------------------------
    // Cursor overlay
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            hsync_q <= 1'b0;
        else
            hsync_q <= hsync_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i || !cursor_window_i)
            cursor_row_cnt <= 4'h0;
        else if (hsync_i && !hsync_q)
            cursor_row_cnt <= cursor_row_cnt + 4'h1;
    end

    // Positions beyond the last legal origin are pulled back to it.
    assign cx = cursor_x_i > CURSOR_MAX_X ? CURSOR_MAX_X : cursor_x_i;
    assign cdat48  = {32'h00000000, cursor_mem[cursor_row_cnt]} << cx[4:0];
    assign carea48 = {32'h00000000, 16'hffff} << cx[4:0];
    assign cursor_word_next = {1'b0, cx[9:5]} + 6'h01;

    always_comb
    begin
        cdat  = 32'h00000000;
        carea = 32'h00000000;
        if (cursor_window_i && word_q == cx[9:5])
        begin
            cdat  = cdat48[31:0];
            carea = carea48[31:0];
        end
        else if (cursor_window_i && {1'b0, word_q} == cursor_word_next)
        begin
            cdat  = {16'h0000, cdat48[47:32]};
            carea = {16'h0000, carea48[47:32]};
        end
    end

    // Bit n of word w is pixel x = 32*w + n, so bit 0 lies leftmost.
    always_comb
    begin
        if (half_page_i && word_q >= HALF_PAGE_WORDS)
            next_pixel = 32'h00000000;
        else if (cursor_or_mode_i)
            next_pixel = fb_word | cdat;
        else
            next_pixel = fb_word & (cdat | ~carea);
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pixel_word_o  <= 32'h00000000;
            pixel_valid_o <= 1'b0;
        end
        else
        begin
            pixel_valid_o <= disp_acc && de_q;
            if (disp_acc && de_q)
                pixel_word_o <= next_pixel;
        end
    end

endmodule

`default_nettype wire

// ===== src/video_mem_host.sv
// Host end: turns user commands into single bus transfers.
`timescale 1ns/1ps
`default_nettype none

module video_mem_host
    import video_mem_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    video_bus_if.host        bus,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [21:0] cmd_addr_i,
    input  wire logic [31:0] cmd_wdata_i,
    input  wire logic [3:0]  cmd_be_i,
    output logic             cmd_ready_o,
    output logic             resp_valid_o,
    output logic [31:0]      resp_rdata_o
);

    // ------------------------------------------------------------
    // Transfer holding
    // ------------------------------------------------------------
    logic        pending;
    logic        write;
    logic [21:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;

    // Only one transfer is outstanding; the device may hold it for up
    // to a full access cycle before its update half comes round.
    assign cmd_ready_o = !pending;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            pending <= 1'b0;
        else if (cmd_valid_i && !pending)
            pending <= 1'b1;
        else if (bus.ack)
            pending <= 1'b0;
    end

    // Line, byte, map and cursor locations are all plain window
    // addresses; bits 17:7 select a line.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            write <= 1'b0;
            addr  <= 22'h000000;
            wdata <= 32'h00000000;
            be    <= 4'h0;
        end
        else if (cmd_valid_i && !pending)
        begin
            write <= cmd_write_i;
            addr  <= cmd_addr_i;
            wdata <= cmd_wdata_i;
            be    <= cmd_be_i;
        end
    end

    // Cursor origins past the legal range are clamped downstream.
    assign bus.req   = pending && !bus.ack;
    assign bus.write = write;
    assign bus.addr  = addr;
    assign bus.wdata = wdata;
    assign bus.be    = be;

    // ------------------------------------------------------------
    // Response
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            resp_valid_o <= 1'b0;
            resp_rdata_o <= 32'h00000000;
        end
        else
        begin
            resp_valid_o <= bus.ack;
            if (bus.ack)
                resp_rdata_o <= bus.rdata;
        end
    end

endmodule

`default_nettype wire
